// File: fspi_pkg.sv
/*
 fspi_pkg: constants and types shared by the memory end and the controller end
 of the serial memory link.
 assumes: core_clk of 10 MHz on both ends; the controller is reached over APB.
*/
// ==========================================================================
// shared constants
package fspi_pkg;
   // timing
   localparam int CORE_CLK_HZ = 10_000_000;
   localparam int SCK_MAX_HZ = 10_000_000;
   localparam int SCK_HALF_NS = 400;
   // least time, so round up to whole core cycles
   localparam int SCK_HALF_CYC = (SCK_HALF_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;
   // array geometry
   localparam int ARRAY_DEPTH = 8192;
   localparam int ARRAY_AW = 13;
   localparam int CMD_AW = 16;
   localparam int ID_BITS = 32;
   // operation codes
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_RDSR = 8'h05;
   localparam logic [7:0] OP_WRSR = 8'h01;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] OP_RDID = 8'h9F;
   localparam logic [7:0] OP_SLEEP = 8'hB9;
   // status byte fields
   localparam int ST_GUARD = 7;
   localparam int ST_SPARE_HI = 6;
   localparam int ST_SPARE_LO = 4;
   localparam int ST_BP_HI = 3;
   localparam int ST_BP_LO = 2;
   localparam int ST_LATCH = 1;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // positions of the pins in the memory's synchroniser vector
   localparam int PIN_CS = 0;
   localparam int PIN_SCK = 1;
   localparam int PIN_SI = 2;
   localparam int PIN_HOLD = 3;
   localparam int PIN_WP = 4;
   localparam int PIN_N = 5;
   // controller registers (byte offsets)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_TX = 8'h04;
   localparam logic [7:0] REG_RX = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0C;
   localparam int CTRL_MODE3 = 0;
   localparam int CTRL_PAUSE = 1;
   localparam int CTRL_WP_LEVEL = 2;
   localparam logic [2:0] CTRL_RESET = 3'h4;
   localparam int TX_LAST = 8;
   localparam int STAT_BUSY = 0;
   localparam int STAT_SEL = 1;
   // command phase of the memory end
   typedef enum logic [1:0] {PH_OP, PH_ADDR, PH_DATA, PH_DONE} fspi_phase_t;
   // bit engine of the controller end
   typedef enum logic [2:0] {C_IDLE, C_LEAD, C_LOW, C_HIGH, C_TRAIL} fspi_cst_t;
endpackage

// File: fspi_if.sv
/*
 fspi_if: the serial pins between the memory end and the controller end.
 assumes: the serial output has a pull-up on the board, so it reads high
 whenever the memory does not drive it.
*/
// ==========================================================================
// pin bundle
interface fspi_if;
   logic cs_n;
   logic sck;
   logic si;
   logic hold_n;
   logic wp_n;
   logic so_o;
   logic so_oe;
   logic so;
   // resolved serial output level, pull-up when released
   assign so = so_oe ? so_o : 1'b1;
   modport mem (input cs_n, input sck, input si, input hold_n, input wp_n,
      output so_o, output so_oe);
   modport ctrl (output cs_n, output sck, output si, output hold_n, output wp_n,
      input so);
endinterface

// File: fspi_mem.sv
/*
 fspi_mem: memory end of the serial link, an 8192 x 8 nonvolatile array
 behind a mode 0 / mode 3 serial target with select, pause and write guard.
 assumes: every pin comes from outside core_clk's domain and is resynchronised
 here; the serial clock runs at most at a third of core_clk's half rate.
*/
// The APB slave port and the placing of the registers were chosen for this implementation.
module fspi_mem #(
   // identification word; the value is arbitrary
   parameter logic [31:0] DEVICE_ID = 32'h1234_5678
) (
   input wire logic core_clk,
   input wire logic rst,
   fspi_if.mem pins,
   output logic write_enable_latch,
   output logic [7:0] status_value,
   output logic sleep_active
);

   // ======================================================================
   // state
   typedef struct packed {
      logic [fspi_pkg::PIN_N-1:0] s1;
      logic [fspi_pkg::PIN_N-1:0] s2;
      logic sck_q;
      logic cs_q;
      fspi_pkg::fspi_phase_t phase;
      logic [4:0] cnt;
      logic [15:0] sh;
      logic [7:0] op;
      logic [fspi_pkg::ARRAY_AW-1:0] addr;
      logic [4:0] ocnt;
      logic out_on;
      logic so;
      logic so_oe;
      logic wlatch;
      logic guard;
      logic [2:0] spare;
      logic [1:0] bp;
      logic sleep_arm;
      logic sleep;
      logic skip;
      logic we;
      logic [fspi_pkg::ARRAY_AW-1:0] waddr;
      logic [7:0] wdata;
   } fspi_mem_state_t;

   localparam fspi_mem_state_t MEM_RESET = '{
      // clock bit low in both stages, like sck_q, so no false edge follows reset
      s1: 5'h19, s2: 5'h19, sck_q: 1'b0, cs_q: 1'b1,
      phase: fspi_pkg::PH_OP, cnt: 5'h00, sh: 16'h0000, op: 8'h00,
      addr: 13'h0000, ocnt: 5'h00, out_on: 1'b0, so: 1'b0, so_oe: 1'b0,
      wlatch: 1'b0, guard: fspi_pkg::STATUS_RESET[fspi_pkg::ST_GUARD],
      spare: fspi_pkg::STATUS_RESET[fspi_pkg::ST_SPARE_HI:fspi_pkg::ST_SPARE_LO],
      bp: fspi_pkg::STATUS_RESET[fspi_pkg::ST_BP_HI:fspi_pkg::ST_BP_LO],
      sleep_arm: 1'b0, sleep: 1'b0, skip: 1'b0,
      we: 1'b0, waddr: 13'h0000, wdata: 8'h00};

   fspi_mem_state_t r;
   fspi_mem_state_t n;

   // the array itself; not reset, it is the nonvolatile content
   logic [7:0] mem [fspi_pkg::ARRAY_DEPTH];

   logic cs_n;
   logic sck;
   logic si;
   logic hold_n;
   logic wp_n;
   logic rise;
   logic fall;
   logic [15:0] bits;
   logic [7:0] rd_byte;
   logic [7:0] st_byte;

   // ======================================================================
   // decoded pin levels, all taken from the second synchroniser stage
   assign cs_n = r.s2[fspi_pkg::PIN_CS];
   assign sck = r.s2[fspi_pkg::PIN_SCK];
   assign si = r.s2[fspi_pkg::PIN_SI];
   assign hold_n = r.s2[fspi_pkg::PIN_HOLD];
   assign wp_n = r.s2[fspi_pkg::PIN_WP];
   // edges found against the previous synchronised level
   assign rise = sck & ~r.sck_q;
   assign fall = ~sck & r.sck_q;
   assign bits = {r.sh[14:0], si};
   assign rd_byte = mem[r.addr];
   // bit 0 reads as zero always
   assign st_byte = {r.guard, r.spare, r.bp, r.wlatch, 1'b0};

   // ======================================================================
   // next state
   always_comb begin
      n = r;
      n.s1 = {pins.wp_n, pins.hold_n, pins.si, pins.sck, pins.cs_n};
      n.s2 = r.s1;
      n.sck_q = sck;
      n.cs_q = cs_n;
      n.we = 1'b0;
      if (cs_n) begin
         // deselected: release output, drop any partial opcode
         n.phase = fspi_pkg::PH_OP;
         n.cnt = 5'h00;
         n.ocnt = 5'h00;
         n.out_on = 1'b0;
         n.so_oe = 1'b0;
         n.skip = 1'b0;
         n.sleep_arm = 1'b0;
         // sleep only if no clock followed the opcode
         if (!r.cs_q && r.sleep_arm) begin
            n.sleep = 1'b1;
         end
      end else if (r.cs_q) begin
         // select just fell; a frame that wakes the part is not decoded,
         // which stands in for the wake-up delay
         n.skip = r.sleep;
         n.sleep = 1'b0;
      end else if (!hold_n || r.skip) begin
         // paused: nothing moves, output released until resumed
         n.so_oe = 1'b0;
      end else begin
         n.so_oe = r.out_on;
         if (rise) begin
            // input shift on the rising edge, either mode
            n.sh = bits;
            n.cnt = r.cnt + 5'h01;
            n.sleep_arm = 1'b0;
            case (r.phase)
               fspi_pkg::PH_OP: begin
                  if (r.cnt == 5'h07) begin
                     n.op = bits[7:0];
                     n.cnt = 5'h00;
                     n.phase = fspi_pkg::PH_DATA;
                     case (bits[7:0])
                        fspi_pkg::OP_WREN: n.wlatch = 1'b1;
                        fspi_pkg::OP_WRDI: n.wlatch = 1'b0;
                        fspi_pkg::OP_READ: n.phase = fspi_pkg::PH_ADDR;
                        fspi_pkg::OP_WRITE: n.phase = fspi_pkg::PH_ADDR;
                        fspi_pkg::OP_SLEEP: n.sleep_arm = 1'b1;
                        default: ;
                     endcase
                  end
               end
               fspi_pkg::PH_ADDR: begin
                  if (r.cnt == 5'h0F) begin
                     // top three address bits dropped
                     n.addr = bits[fspi_pkg::ARRAY_AW-1:0];
                     n.cnt = 5'h00;
                     n.phase = fspi_pkg::PH_DATA;
                  end
               end
               fspi_pkg::PH_DATA: begin
                  if (r.cnt == 5'h07) begin
                     n.cnt = 5'h00;
                     if (r.op == fspi_pkg::OP_WRITE) begin
                        // byte lands in the array next cycle, no busy time
                        n.we = r.wlatch;
                        n.waddr = r.addr;
                        n.wdata = bits[7:0];
                        n.addr = r.addr + 13'h0001; // wraps at the top
                     end
                     if (r.op == fspi_pkg::OP_WRSR) begin
                        n.phase = fspi_pkg::PH_DONE;
                        // latch bit and bit 0 are not writable this way
                        if (r.wlatch && !(r.guard && !wp_n)) begin
                           n.guard = bits[fspi_pkg::ST_GUARD];
                           n.spare = bits[fspi_pkg::ST_SPARE_HI:fspi_pkg::ST_SPARE_LO];
                           n.bp = bits[fspi_pkg::ST_BP_HI:fspi_pkg::ST_BP_LO];
                        end
                     end
                  end
               end
               default: n.cnt = 5'h00;
            endcase
         end
         if (fall && r.phase == fspi_pkg::PH_DATA) begin
            // output changes only on the falling edge
            case (r.op)
               fspi_pkg::OP_READ: begin
                  n.so = rd_byte[~r.ocnt[2:0]];
                  if (r.ocnt[2:0] == 3'h7) begin
                     n.addr = r.addr + 13'h0001;
                  end
               end
               fspi_pkg::OP_RDSR: n.so = st_byte[~r.ocnt[2:0]];
               fspi_pkg::OP_RDID: n.so = DEVICE_ID[~r.ocnt];
               default: n.so = 1'b0;
            endcase
            n.out_on = 1'b1;
            n.so_oe = 1'b1;
            // the identification word holds its last bit
            if (!(r.op == fspi_pkg::OP_RDID && r.ocnt == 5'h1F)) begin
               n.ocnt = r.ocnt + 5'h01;
            end
         end
      end
   end

   // ======================================================================
   // state register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         r <= MEM_RESET;
      end else begin
         r <= n;
      end
   end

   // array write port, fed by the registered strobe
   always_ff @(posedge core_clk) begin
      if (r.we) begin
         mem[r.waddr] <= r.wdata;
      end
   end

   // ======================================================================
   // outputs, all straight from state
   assign pins.so_o = r.so;
   assign pins.so_oe = r.so_oe;
   assign write_enable_latch = r.wlatch;
   assign status_value = st_byte;
   assign sleep_active = r.sleep;

endmodule // fspi_mem

// File: fspi_ctrl.sv
/*
 fspi_ctrl: controller end of the serial link, a byte engine commanded
 over APB that drives select, clock, data, pause and write guard.
 assumes: APB runs on core_clk; the serial output comes from another part
 and is resynchronised here.
*/
module fspi_ctrl #(
   parameter int HALF_CYC = fspi_pkg::SCK_HALF_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   fspi_if.ctrl pins
);

   // ======================================================================
   // state
   typedef struct packed {
      logic s1;
      logic s2;
      logic pready;
      logic [31:0] prdata;
      logic mode3;
      logic hold_n;
      logic wp_n;
      fspi_pkg::fspi_cst_t st;
      logic [15:0] div;
      logic [2:0] bitn;
      logic [7:0] tx;
      logic [7:0] rx;
      logic last;
      logic cs_n;
      logic sck;
      logic mosi;
   } fspi_ctrl_state_t;

   localparam fspi_ctrl_state_t CTRL_RST = '{
      s1: 1'b1, s2: 1'b1, pready: 1'b0, prdata: 32'h0000_0000,
      mode3: fspi_pkg::CTRL_RESET[fspi_pkg::CTRL_MODE3],
      hold_n: ~fspi_pkg::CTRL_RESET[fspi_pkg::CTRL_PAUSE],
      wp_n: fspi_pkg::CTRL_RESET[fspi_pkg::CTRL_WP_LEVEL],
      st: fspi_pkg::C_IDLE, div: 16'h0000, bitn: 3'h0, tx: 8'h00, rx: 8'h00,
      last: 1'b0, cs_n: 1'b1, sck: 1'b0, mosi: 1'b0};

   // rate limit: one half period is never below one core cycle
   localparam logic [15:0] HALF_LAST = 16'((HALF_CYC < 1 ? 1 : HALF_CYC) - 1);

   fspi_ctrl_state_t r;
   fspi_ctrl_state_t n;
   logic tick;
   logic busy;
   logic wr;

   assign tick = (r.div == HALF_LAST);
   assign busy = (r.st != fspi_pkg::C_IDLE);
   assign wr = psel & penable & r.pready & pwrite;

   // ======================================================================
   // next state: bus slave and bit engine
   always_comb begin
      n = r;
      n.s1 = pins.so;
      n.s2 = r.s1;
      // zero-wait slave: ready in the cycle after setup
      n.pready = psel & ~penable;
      n.prdata = 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
         case (paddr)
            fspi_pkg::REG_CTRL: n.prdata[2:0] = {r.wp_n, ~r.hold_n, r.mode3};
            fspi_pkg::REG_RX: n.prdata[7:0] = r.rx;
            fspi_pkg::REG_STAT: n.prdata[1:0] = {~r.cs_n, busy};
            default: n.prdata = 32'h0000_0000;
         endcase
      end
      if (wr && paddr == fspi_pkg::REG_CTRL) begin
         // mode bit only counts while idle, so no stray edge mid-frame
         if (!busy && r.cs_n) begin
            n.mode3 = pwdata[fspi_pkg::CTRL_MODE3];
         end
         n.hold_n = ~pwdata[fspi_pkg::CTRL_PAUSE];
         n.wp_n = pwdata[fspi_pkg::CTRL_WP_LEVEL];
      end
      // a byte written while busy is dropped
      if (wr && paddr == fspi_pkg::REG_TX && !busy) begin
         n.tx = pwdata[7:0];
         n.last = pwdata[fspi_pkg::TX_LAST];
         n.div = 16'h0000;
         n.st = r.cs_n ? fspi_pkg::C_LEAD : fspi_pkg::C_LOW;
         n.cs_n = 1'b0;
         if (!r.cs_n) begin
            n.sck = 1'b0;
            n.mosi = pwdata[7];
         end
      end
      // the engine freezes while paused, so no bit is lost
      if (busy && r.hold_n) begin
         n.div = tick ? 16'h0000 : r.div + 16'h0001;
         if (tick) begin
            case (r.st)
               fspi_pkg::C_LEAD: begin
                  // select has led by a half period; in mode 3 this is the first edge, in mode 0 the first edge comes a half period later
                  n.st = fspi_pkg::C_LOW;
                  n.sck = 1'b0;
                  n.mosi = r.tx[7];
               end
               fspi_pkg::C_LOW: begin
                  n.st = fspi_pkg::C_HIGH;
                  n.sck = 1'b1;
               end
               fspi_pkg::C_HIGH: begin
                  // sample late in the high half, the far end answers slowly
                  n.rx = {r.rx[6:0], r.s2};
                  n.tx = {r.tx[6:0], 1'b0};
                  n.bitn = r.bitn + 3'h1;
                  if (r.bitn == 3'h7) begin
                     n.sck = r.mode3;
                     n.st = r.last ? fspi_pkg::C_TRAIL : fspi_pkg::C_IDLE;
                  end else begin
                     n.st = fspi_pkg::C_LOW;
                     n.sck = 1'b0;
                     n.mosi = r.tx[6];
                  end
               end
               fspi_pkg::C_TRAIL: begin
                  n.cs_n = 1'b1;
                  n.st = fspi_pkg::C_IDLE;
               end
               default: n.st = fspi_pkg::C_IDLE;
            endcase
         end
      end
      if (!busy && r.cs_n) begin
         // idle clock level follows the chosen mode
         n.sck = r.mode3;
      end
   end

   // ======================================================================
   // state register
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         r <= CTRL_RST;
      end else begin
         r <= n;
      end
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = 1'b0;
   assign pins.cs_n = r.cs_n;
   assign pins.sck = r.sck;
   assign pins.si = r.mosi;
   assign pins.hold_n = r.hold_n;
   assign pins.wp_n = r.wp_n;

endmodule // fspi_ctrl

// File: fspi_asserts.sv
/*
 fspi_asserts: pin-level checks between controller end and memory end.
 assumes: instantiated beside fspi_if in tb_top, fed its signals by name.
*/
// ==========================================================================
// checker
module fspi_asserts #(
   parameter int HALF_CYC = 4
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic hold_n,
   input wire logic wp_n,
   input wire logic so_o,
   input wire logic so_oe,
   input wire logic so
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] hi_cnt;
   logic [2:0] rise_cnt;
   logic sck_q;
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // high-time counter saturates so long idles never wrap; rising-edge counter wraps every eight edges
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hi_cnt <= 8'h00;
         rise_cnt <= 3'h0;
         sck_q <= 1'b0;
      end else begin
         sck_q <= sck;
         hi_cnt <= !sck ? 8'h00 : ((hi_cnt == 8'hFF) ? hi_cnt : hi_cnt + 8'h01);
         rise_cnt <= cs_n ? 3'h0 : (rise_cnt + {2'h0, sck & ~sck_q});
      end
   end
   // ==========================================================================
   // assertions; the memory sees pins about three cycles late, hence six
   AST_DESELECT_RELEASE: assert property (cs_n [*6] |-> !so_oe)
      else $error("output driven while deselected");
   AST_PAUSE_RELEASE: assert property ((!hold_n) [*6] |-> !so_oe)
      else $error("output driven while paused");
   AST_SELECT_FIRST: assert property ($fell(cs_n) |-> $stable(sck) [*6])
      else $error("clock moved too soon after select");
   AST_PAUSE_FREEZE: assert property (!hold_n && !$past(hold_n) |-> $stable(sck))
      else $error("clock moved during pause");
   AST_OUT_ON_FALL: assert property (so_oe && $past(so_oe) && $changed(so_o) |-> !sck)
      else $error("output changed while clock high");
   AST_CLOCK_RATE: assert property ($fell(sck) |-> hi_cnt >= HALF_CYC)
      else $error("clock high time too short");
   AST_WHOLE_BYTES: assert property ($rose(cs_n) |-> rise_cnt == 3'h0)
      else $error("frame ended in mid byte");
   AST_IN_STEADY: assert property (!cs_n && sck && $past(sck) |-> $stable(si))
      else $error("input moved while clock high");
   // main scenarios reached
   cover property ($rose(so_oe));
   cover property ($fell(hold_n) && !cs_n);
   cover property ($fell(cs_n) && sck);
   cover property (!wp_n && $rose(cs_n) && so);
endmodule // fspi_asserts

// File: tb_top.sv
/*
 tb_top: drives the controller end over APB, the memory end answers over
 the pins; read data come back through the receive register, latch, status and sleep from the memory end's ports.
 assumes: fspi_pkg, fspi_if, fspi_ctrl, fspi_mem compiled before.
*/
// ==========================================================================
// bench top
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HALF = 6;
   // identification word; the value is arbitrary
   localparam logic [31:0] ID = 32'hA5C3_0F96;
   localparam logic [8:0] NC = 9'h000;
   logic core_clk = 1'b0;
   logic rst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic wr_latch;
   logic sleep;
   logic [7:0] status;
   logic [8:0] expq[$];
   logic [8:0] e_m;
   logic [2:0] ctrl_v = fspi_pkg::CTRL_RESET;
   int n_mismatch = 0;
   int cmp_count = 0;
   fspi_if bus();
   fspi_ctrl #(.HALF_CYC(HALF)) fspi_ctrl_i (.core_clk(core_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pins(bus.ctrl));
   fspi_mem #(.DEVICE_ID(ID)) fspi_mem_i (.core_clk(core_clk), .rst(rst), .pins(bus.mem),
      .write_enable_latch(wr_latch), .status_value(status), .sleep_active(sleep));
   fspi_asserts #(.HALF_CYC(HALF)) fspi_asserts_i (.core_clk(core_clk), .rst(rst),
      .cs_n(bus.cs_n), .sck(bus.sck), .si(bus.si), .hold_n(bus.hold_n), .wp_n(bus.wp_n),
      .so_o(bus.so_o), .so_oe(bus.so_oe), .so(bus.so));
   // 100 ns clock
   always #50 core_clk = ~core_clk;
   // ==========================================================================
   // verdict
   task results;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one APB transfer; pready and prdata are taken at the rising edge that ends it
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] r);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 100);
      if (pready !== 1'b1) begin
         n_mismatch++;
         results();
      end
      r = prdata;
      // release, then let an edge pass so the next setup never overwrites it
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic setctrl;
      logic [31:0] r;
      apb(fspi_pkg::REG_CTRL, 1'b1, {29'h0, ctrl_v}, r);
   endtask
   // one byte over the link; pz pauses it just after it starts, e notes the expected reply
   task automatic xfer(input logic [7:0] b, input logic last, input logic [8:0] e,
      input logic pz);
      logic [31:0] r;
      int k;
      apb(fspi_pkg::REG_TX, 1'b1, {23'h0, last, b}, r);
      if (pz) begin
         apb(fspi_pkg::REG_CTRL, 1'b1, {29'h0, ctrl_v | 3'h2}, r);
         repeat (40) @(posedge core_clk);
         apb(fspi_pkg::REG_STAT, 1'b0, 32'h0, r);
         check({7'h0, r[fspi_pkg::STAT_BUSY]}, 8'h01);
         setctrl();
      end
      k = 0;
      do begin
         apb(fspi_pkg::REG_STAT, 1'b0, 32'h0, r);
         k++;
      end while (r[fspi_pkg::STAT_BUSY] !== 1'b0 && k < 500);
      if (r[fspi_pkg::STAT_BUSY] !== 1'b0) begin
         n_mismatch++;
         results();
      end
      expq.push_back(e);
      apb(fspi_pkg::REG_RX, 1'b0, 32'h0, r);
   endtask
   task automatic one(input logic [7:0] op);
      xfer(op, 1'b1, NC, 1'b0);
   endtask
   task automatic hdr(input logic [7:0] op, input logic [15:0] a);
      xfer(op, 1'b0, NC, 1'b0);
      xfer(a[15:8], 1'b0, NC, 1'b0);
      xfer(a[7:0], 1'b0, NC, 1'b0);
   endtask
   // scoreboard: each receive-register read takes the oldest note
   always @(posedge core_clk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0
         && paddr === fspi_pkg::REG_RX) begin
         e_m = (expq.size() > 0) ? expq.pop_front() : NC;
         if (e_m[8]) begin
            check(prdata[7:0], e_m[7:0]);
         end
      end
   end
   // ==========================================================================
   // main sequence
   initial begin
      logic [15:0] a;
      logic [7:0] d0;
      logic [7:0] d1;
      logic [7:0] d2;
      int s;
      s = $urandom(61);
      // a rising reset at time zero, so asynchronous resets act before the first edge
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      repeat (6) @(posedge core_clk);
      xfer(fspi_pkg::OP_RDSR, 1'b0, NC, 1'b0);
      xfer(8'h00, 1'b1, {1'b1, fspi_pkg::STATUS_RESET}, 1'b0);
      check({7'h0, wr_latch}, 8'h00);
      // both clock modes; addresses kept clear of the wrap pair
      for (int m = 0; m < 2; m++) begin
         ctrl_v[fspi_pkg::CTRL_MODE3] = m[0];
         setctrl();
         a = {3'($urandom), 5'h05, 8'($urandom)};
         d0 = 8'($urandom);
         d1 = 8'($urandom);
         d2 = 8'($urandom);
         one(fspi_pkg::OP_WREN);
         check({7'h0, wr_latch}, 8'h01);
         hdr(fspi_pkg::OP_WRITE, a);
         xfer(d0, 1'b0, NC, 1'b0);
         xfer(d1, 1'b1, NC, 1'b0);
         hdr(fspi_pkg::OP_READ, {~a[15:13], a[12:0]});
         xfer(8'h00, 1'b0, {1'b1, d0}, 1'b0);
         xfer(8'h00, 1'b1, {1'b1, d1}, 1'b1);
         hdr(fspi_pkg::OP_WRITE, 16'h1FFF);
         xfer(d2, 1'b0, NC, 1'b0);
         xfer(~d1, 1'b1, NC, 1'b0);
         hdr(fspi_pkg::OP_READ, 16'hE000);
         xfer(8'h00, 1'b1, {1'b1, ~d1}, 1'b0);
         one(fspi_pkg::OP_WRDI);
         check({7'h0, wr_latch}, 8'h00);
         hdr(fspi_pkg::OP_WRITE, a);
         xfer(~d0, 1'b1, NC, 1'b0);
         hdr(fspi_pkg::OP_READ, a);
         xfer(8'h00, 1'b1, {1'b1, d0}, 1'b0);
      end
      // status writes under the guard pin
      one(fspi_pkg::OP_WREN);
      xfer(fspi_pkg::OP_WRSR, 1'b0, NC, 1'b0);
      xfer(8'h8D, 1'b1, NC, 1'b0);
      check(status, 8'h8E);
      xfer(fspi_pkg::OP_RDSR, 1'b0, NC, 1'b0);
      xfer(8'h00, 1'b0, {1'b1, 8'h8E}, 1'b0);
      xfer(8'h00, 1'b1, {1'b1, 8'h8E}, 1'b0);
      ctrl_v[fspi_pkg::CTRL_WP_LEVEL] = 1'b0;
      setctrl();
      xfer(fspi_pkg::OP_WRSR, 1'b0, NC, 1'b0);
      xfer(8'h00, 1'b1, NC, 1'b0);
      check(status, 8'h8E);
      ctrl_v[fspi_pkg::CTRL_WP_LEVEL] = 1'b1;
      setctrl();
      xfer(fspi_pkg::OP_WRSR, 1'b0, NC, 1'b0);
      xfer(8'h00, 1'b1, NC, 1'b0);
      check(status, 8'h02);
      // identification word, most significant byte first
      xfer(fspi_pkg::OP_RDID, 1'b0, NC, 1'b0);
      for (int i = 0; i < 4; i++) begin
         xfer(8'h00, i == 3, {1'b1, ID[31 - 8 * i -: 8]}, 1'b0);
      end
      // sleep with no clock after the opcode; the next frame only wakes the part
      one(fspi_pkg::OP_SLEEP);
      check({7'h0, sleep}, 8'h01);
      one(fspi_pkg::OP_WRDI);
      check({7'h0, sleep}, 8'h00);
      check({7'h0, wr_latch}, 8'h01);
      results();
   end
endmodule // tb_top
